// ---- common/sadc_pkg.sv ----
// How it works
// - Chain select low: read enable low gates the serial output.
// - Chain select high: shared pin is serial data from upstream converter.
// - Rising convert_start wakes the device and starts a conversion.
// - Busy rises when conversion starts, falls when it completes.
// - One bit per shift clock rising edge, MSB first, result or chain data.
// - End of conversion loads a 16-bit straight binary word for shifting.
// - Acquisition tracks input; conversion holds the sample and resolves it.
// - Sixteen successive approximation steps, half scale down to one LSB.
// - Conversion is timed by the internal clock, not the shift clock.
// - Powers down between conversions; next convert_start resumes.
package sadc_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing.
  // ---------------------------------------------------------------
  localparam int unsigned SADC_RES_BITS = 16;
  localparam int unsigned SADC_CLK_MHZ = 25;
  // Settle time allowed per approximation step, in ns.
  localparam int unsigned SADC_STEP_NS = 40;
  localparam int unsigned SADC_STEP_CYC =
      (SADC_STEP_NS * SADC_CLK_MHZ + 999) / 1000 < 1 ? 1 :
      (SADC_STEP_NS * SADC_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] SADC_ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    SADC_ST_SLEEP,
    SADC_ST_ACQ,
    SADC_ST_CONV
  } sadc_state_e;

endpackage

// ---- verilog/sadc_shift_out.sv ----
`timescale 1ns/1ps
// Link-side shift register, clocked by the host shift clock.
module sadc_shift_out #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic shift_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] load_word,
  input wire logic load_tgl,
  input wire logic chain_in,
  output logic serial_bit
);

  typedef struct packed {
    logic [WIDTH-1:0] shreg;
    logic [1:0] tgl_sync;
    logic tgl_seen;
    logic [1:0] rst_sync;
  } sadc_link_s;

  sadc_link_s st_reg;
  sadc_link_s st_next;

  // ---------------------------------------------------------------
  // Load on a fresh result toggle, otherwise shift toward the MSB.
  // ---------------------------------------------------------------
  // The word is held stable in the core domain long before the toggle
  // arrives here, so sampling it directly on the toggle is safe.
  always_comb begin
    st_next = st_reg;
    st_next.rst_sync = {st_reg.rst_sync[0], reset};
    st_next.tgl_sync = {st_reg.tgl_sync[0], load_tgl};
    st_next.tgl_seen = st_reg.tgl_sync[1];
    if (st_reg.tgl_sync[1] != st_reg.tgl_seen) begin
      st_next.shreg = load_word;
    end else begin
      st_next.shreg = {st_reg.shreg[WIDTH-2:0], chain_in};
    end
    if (st_reg.rst_sync[1]) begin
      st_next.shreg = '0;
    end
  end

  always_ff @(posedge shift_clk) begin
    st_reg <= st_next;
  end

  // MSB sits on the output; each rising edge exposes the next bit.
  assign serial_bit = st_reg.shreg[WIDTH-1];

endmodule

// ---- verilog/sadc_core.sv ----
`timescale 1ns/1ps
// Conversion control and serial readout of a successive-approximation converter.
module sadc_core #(
  parameter int unsigned RES_BITS = sadc_pkg::SADC_RES_BITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic convert_start,
  input wire logic chain_select,
  input wire logic read_enable_or_chain_in,
  input wire logic shift_clk,
  input wire logic comparator_high,
  output logic busy,
  output logic [RES_BITS-1:0] sampling_cap_dac,
  output logic sample_hold,
  output logic powered_up,
  output logic serial_out,
  output logic serial_out_en
);

  // The reset word in the package is 16 bits wide, so wider results are refused.
  if (RES_BITS < 2 || RES_BITS > 16) begin : g_bad_width
    $error("RES_BITS out of range");
  end

  typedef struct packed {
    sadc_pkg::sadc_state_e state;
    logic [2:0] cnv_sync;
    logic [1:0] cmp_sync;
    logic [1:0] chain_sync;
    logic [1:0] rdl_sync;
    logic [RES_BITS-1:0] trial;
    logic [RES_BITS-1:0] bit_mask;
    logic [7:0] step_cnt;
    logic [RES_BITS-1:0] result;
    logic load_tgl;
    logic busy;
    logic hold;
    logic pwr;
    logic oe;
  } sadc_core_s;

  sadc_core_s st_reg;
  sadc_core_s st_next;
  logic link_bit;

  // ---------------------------------------------------------------
  // Conversion sequencer on the internal clock.
  // ---------------------------------------------------------------
  // The comparator settles over a step time before it is judged; the
  // two-stage sync adds latency that the step count already absorbs.
  always_comb begin
    st_next = st_reg;
    st_next.cnv_sync = {st_reg.cnv_sync[1:0], convert_start};
    st_next.cmp_sync = {st_reg.cmp_sync[0], comparator_high};
    st_next.chain_sync = {st_reg.chain_sync[0], chain_select};
    st_next.rdl_sync = {st_reg.rdl_sync[0], read_enable_or_chain_in};
    case (st_reg.state)
      sadc_pkg::SADC_ST_SLEEP: begin
        st_next.pwr = 1'b0;
        st_next.hold = 1'b0;
        if (st_reg.cnv_sync[1] && !st_reg.cnv_sync[2]) begin
          st_next.pwr = 1'b1;
          st_next.state = sadc_pkg::SADC_ST_CONV;
          st_next.busy = 1'b1;
          st_next.hold = 1'b1;
          st_next.bit_mask = {1'b1, {(RES_BITS-1){1'b0}}};
          st_next.trial = {1'b1, {(RES_BITS-1){1'b0}}};
          st_next.step_cnt = 8'h00;
        end
      end
      sadc_pkg::SADC_ST_CONV: begin
        if (st_reg.step_cnt < 8'(sadc_pkg::SADC_STEP_CYC + 2)) begin
          st_next.step_cnt = st_reg.step_cnt + 8'h01;
        end else begin
          st_next.step_cnt = 8'h00;
          // Keep the trial bit only if the sample lies at or above the DAC level.
          if (!st_reg.cmp_sync[1]) begin
            st_next.trial = st_reg.trial & ~st_reg.bit_mask;
          end
          if (st_reg.bit_mask[0]) begin
            st_next.result = st_reg.cmp_sync[1] ? st_reg.trial
                             : (st_reg.trial & ~st_reg.bit_mask);
            st_next.load_tgl = ~st_reg.load_tgl;
            st_next.busy = 1'b0;
            st_next.hold = 1'b0;
            st_next.state = sadc_pkg::SADC_ST_ACQ;
          end else begin
            st_next.bit_mask = st_reg.bit_mask >> 1;
            st_next.trial = (st_next.trial | (st_reg.bit_mask >> 1));
          end
        end
      end
      sadc_pkg::SADC_ST_ACQ: begin
        // Tracking costs nothing digital, so drop straight to sleep.
        st_next.state = sadc_pkg::SADC_ST_SLEEP;
        st_next.pwr = 1'b0;
      end
      default: begin
        st_next.state = sadc_pkg::SADC_ST_SLEEP;
      end
    endcase
    // Normal mode: active-low read enable gates the driver; chain mode always drives.
    st_next.oe = st_reg.chain_sync[1] | ~st_reg.rdl_sync[1];
    if (reset) begin
      st_next.state = sadc_pkg::SADC_ST_SLEEP;
      st_next.trial = sadc_pkg::SADC_ZERO_WORD[RES_BITS-1:0];
      st_next.bit_mask = '0;
      st_next.step_cnt = 8'h00;
      st_next.result = sadc_pkg::SADC_ZERO_WORD[RES_BITS-1:0];
      st_next.load_tgl = 1'b0;
      st_next.busy = 1'b0;
      st_next.hold = 1'b0;
      st_next.pwr = 1'b0;
      st_next.oe = 1'b0;
      st_next.cnv_sync = 3'h7; // A high line at reset is not an edge.
    end
  end

  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Link side and output registers.
  // ---------------------------------------------------------------
  sadc_shift_out #(
    .WIDTH(RES_BITS)
  ) u_shift (
    .shift_clk(shift_clk),
    .reset(reset),
    .load_word(st_reg.result),
    .load_tgl(st_reg.load_tgl),
    .chain_in(read_enable_or_chain_in),
    .serial_bit(link_bit)
  );

  // The shift register MSB is already a flop; a second stage would lag one bit.
  assign busy = st_reg.busy;
  assign sampling_cap_dac = st_reg.trial;
  assign sample_hold = st_reg.hold;
  assign powered_up = st_reg.pwr;
  assign serial_out = link_bit;
  assign serial_out_en = st_reg.oe;

endmodule

// ---- tb/sadc_core_asserts.sv ----
`timescale 1ns/1ps
module sadc_core_asserts #(
  parameter int unsigned RES_BITS = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic convert_start,
  input wire logic chain_select,
  input wire logic read_enable_or_chain_in,
  input wire logic busy,
  input wire logic [RES_BITS-1:0] sampling_cap_dac,
  input wire logic sample_hold,
  input wire logic powered_up,
  input wire logic serial_out_en
);
  // Everything here lives in the conversion clock domain.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_go; $rose(busy); endsequence
  sequence s_rd(bit c, bit r); (chain_select == c && read_enable_or_chain_in == r)[*4]; endsequence
  property p_trial; s_go |-> ##[0:1] sampling_cap_dac == {1'b1, {(RES_BITS-1){1'b0}}}; endproperty
  property p_stay; s_go |-> busy[*8]; endproperty
  property p_end; s_go |-> ##[60:70] !busy; endproperty
  property p_start; $rose(convert_start) && !busy && !powered_up |-> ##[2:6] busy; endproperty
  property p_hold; busy && $past(busy) |-> sample_hold && powered_up; endproperty
  property p_sleep; $fell(busy) |-> ##[0:2] !powered_up; endproperty
  property p_off; s_rd(1'b0, 1'b1) |-> !serial_out_en; endproperty
  property p_on; s_rd(1'b0, 1'b0) |-> serial_out_en; endproperty
  property p_chain; chain_select[*4] |-> serial_out_en; endproperty
  a_trial: assert property (p_trial) else $error("first trial not half scale");
  a_stay: assert property (p_stay) else $error("busy dropped early");
  a_end: assert property (p_end) else $error("busy too long");
  a_start: assert property (p_start) else $error("convert edge missed");
  a_hold: assert property (p_hold) else $error("sample not held");
  a_sleep: assert property (p_sleep) else $error("no power down");
  a_off: assert property (p_off) else $error("output not released");
  a_on: assert property (p_on) else $error("output not enabled");
  a_chain: assert property (p_chain) else $error("chain output off");
endmodule
bind sadc_core sadc_core_asserts #(.RES_BITS(RES_BITS)) u_chk (.sys_clk(sys_clk), .reset(reset),
  .convert_start(convert_start), .chain_select(chain_select), .busy(busy),
  .read_enable_or_chain_in(read_enable_or_chain_in), .sampling_cap_dac(sampling_cap_dac),
  .sample_hold(sample_hold), .powered_up(powered_up), .serial_out_en(serial_out_en));

// ---- tb/sadc_front_model.sv ----
`timescale 1ns/1ps
module sadc_front_model (
  input wire logic [15:0] sample,
  input wire logic [15:0] dac,
  output logic comparator_high
);
  // Ideal comparator, so a correct search lands exactly on the sample.
  assign comparator_high = (sample >= dac);
endmodule

// ---- tb/tb_sar_adc_convert_and_serial_readout.sv ----
`timescale 1ns/1ps
module tb_sar_adc_convert_and_serial_readout;
  logic sys_clk = 1'b0, reset = 1'b1, convert_start = 1'b0, chain_select = 1'b0;
  logic rd_in = 1'b1, shift_clk = 1'b0, cmp, busy, s_hold, pwr, sout, sout_en;
  logic [15:0] dac, sample = 16'h0000;
  logic [15:0] corner [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
  logic [31:0] got, up, expv;
  int err_total = 0, n_checks = 0, cyc = 0;
  // Conversion clock; the link clock only moves during reset and inside frames.
  initial forever #20 sys_clk = ~sys_clk;
  sadc_core u_dut (.sys_clk(sys_clk), .reset(reset), .convert_start(convert_start),
    .chain_select(chain_select), .read_enable_or_chain_in(rd_in), .shift_clk(shift_clk),
    .comparator_high(cmp), .busy(busy), .sampling_cap_dac(dac), .sample_hold(s_hold),
    .powered_up(pwr), .serial_out(sout), .serial_out_en(sout_en));
  sadc_front_model u_front (.sample(sample), .dac(dac), .comparator_high(cmp));
  task automatic compare(string what, logic [31:0] exp, logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h got %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Three idle edges let the new word reach the link side first.
  task automatic frame(int n);
    got = '0;
    #13;
    for (int i = -3; i < n; i++) begin
      if (i >= 0) got = {got[30:0], sout};
      if (chain_select && i >= 0) rd_in = up[31-i];
      #40 shift_clk = 1'b1;
      #40 shift_clk = 1'b0;
    end
  endtask
  // Cut a hang short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h1003));
    repeat (4) begin
      #40 shift_clk = 1'b1;
      #40 shift_clk = 1'b0;
    end
    @(posedge sys_clk) #1 reset = 1'b0;
    repeat (500) @(posedge sys_clk) #1;
    for (int t = 0; t < 12; t++) begin
      @(posedge sys_clk) #1;
      sample = t < 4 ? corner[t] : 16'($urandom);
      up = $urandom;
      chain_select = (t >= 10);
      convert_start = 1'b1;
      repeat (3) @(posedge sys_clk) #1;
      convert_start = 1'b0;
      repeat (5) @(posedge sys_clk) #1;
      compare("busy_up", 32'h1, {31'h0, busy});
      for (int k = 0; k < 100 && busy === 1'b1; k++) @(posedge sys_clk) #1;
      compare("busy_down", 32'h0, {31'h0, busy});
      rd_in = 1'b0;
      repeat (4) @(posedge sys_clk) #1;
      compare("enable", 32'h1, {31'h0, sout_en});
      frame(chain_select ? 32 : 16);
      expv = chain_select ? {sample, up[31:16]} : {16'h0, sample};
      compare("word", expv, got);
      @(posedge sys_clk) #1 rd_in = 1'b1;
      repeat (4) @(posedge sys_clk) #1;
      compare("enable", {31'h0, chain_select}, {31'h0, sout_en});
    end
    conclude();
  end
endmodule
